// [hdl/rihmi_map.svh]
// Clock rate, timings in ms and s, and lamp positions for the reader front-panel controller
`ifndef RIHMI_MAP_SVH
`define RIHMI_MAP_SVH
`define RIHMI_CLK_HZ          40000000
`define RIHMI_STARTUP_MS      1000
`define RIHMI_TEST_TMO_S      180
`define RIHMI_SETUP_TMO_S     5
`define RIHMI_LEARN_TMO_S     180
`define RIHMI_DWELL_MS        1000
`define RIHMI_BLINK_MS        250
`define RIHMI_EXIT_DLY_MS     500
`define RIHMI_BEEP_SHORT_MS   100
`define RIHMI_BEEP_LONG_MS    1000
`define RIHMI_DEBOUNCE_MS     20
`define RIHMI_LAMP_STATUS     0
`define RIHMI_LAMP_SERIAL     1
`define RIHMI_LAMP_TRIGGER    2
`define RIHMI_LAMP_GOOD       3
`define RIHMI_LAMP_READY      4
`endif

// [hdl/rihmi_pkg.sv]
// Types shared by the reader front-panel controller
package rihmi_pkg;
    typedef enum logic [7:0] {
        ST_START  = 8'b0000_0001,
        ST_NORMAL = 8'b0000_0010,
        ST_SELECT = 8'b0000_0100,
        ST_TEST   = 8'b0000_1000,
        ST_AIM    = 8'b0001_0000,
        ST_SETUP  = 8'b0010_0000,
        ST_LEARN  = 8'b0100_0000,
        ST_EXIT   = 8'b1000_0000
    } rihmi_state_type;

    typedef struct packed {
        logic read_done;
        logic good_read;
        logic no_read;
        logic phase_active;
        logic serial_active;
        logic ready;
        logic error;
        logic save_ok;
    } rihmi_events_type;

    typedef struct packed {
        logic aim_on;
        logic start_setup;
        logic start_learn;
        logic cancel;
    } rihmi_cmd_type;
endpackage

// [hdl/rihmi_top.sv]
// Front-panel lamp, beeper and push-button controller of the code reader
`timescale 1ns/10ps
`default_nettype none
`include "rihmi_map.svh"
module rihmi_top
    import rihmi_pkg::*;
#(
    parameter int unsigned CLK_HZ = `RIHMI_CLK_HZ,
    parameter int unsigned STARTUP_CYC = CLK_HZ / 1000 * `RIHMI_STARTUP_MS,
    parameter longint unsigned TEST_TMO_CYC = longint'(CLK_HZ) * `RIHMI_TEST_TMO_S,
    parameter int unsigned SETUP_TMO_CYC = CLK_HZ * `RIHMI_SETUP_TMO_S,
    parameter longint unsigned LEARN_TMO_CYC = longint'(CLK_HZ) * `RIHMI_LEARN_TMO_S,
    parameter int unsigned DWELL_CYC = CLK_HZ / 1000 * `RIHMI_DWELL_MS,
    parameter int unsigned BLINK_CYC = CLK_HZ / 1000 * `RIHMI_BLINK_MS,
    parameter int unsigned EXIT_CYC = CLK_HZ / 1000 * `RIHMI_EXIT_DLY_MS,
    parameter int unsigned BEEP_S_CYC = CLK_HZ / 1000 * `RIHMI_BEEP_SHORT_MS,
    parameter int unsigned BEEP_L_CYC = CLK_HZ / 1000 * `RIHMI_BEEP_LONG_MS,
    parameter int unsigned DEBOUNCE_CYC = CLK_HZ / 1000 * `RIHMI_DEBOUNCE_MS
) (
    input  wire logic             CLK_I,
    input  wire logic             RST_I,
    input  wire logic             BUTTON_N_I,
    input  wire logic             NET_LINK_I,
    input  wire logic             FIELDBUS_I,
    input  wire rihmi_events_type EVENTS_I,
    input  wire logic [2:0]       RATE_I,
    output logic                  SUPPLY_LAMP_O,
    output logic                  NET_LAMP_O,
    output logic [4:0]            LAMPS_O,
    output logic                  BEEP_HIGH_O,
    output logic                  BEEP_LOW_O,
    output logic                  GREEN_SPOT_O,
    output rihmi_cmd_type         CMD_O
);
    localparam int unsigned CW = 33;

    // Two-stage synchronisers for the pin inputs; the button pin idles high
    logic [1:0] btn_sync_q;
    logic [1:0] net_s1_q, net_s2_q;
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            btn_sync_q <= 2'h3;
        end else begin
            btn_sync_q <= {btn_sync_q[0], BUTTON_N_I};
        end
    end
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            net_s1_q <= 2'h0;
            net_s2_q <= 2'h0;
        end else begin
            net_s1_q <= {net_s1_q[0], NET_LINK_I};
            net_s2_q <= {net_s2_q[0], FIELDBUS_I};
        end
    end
    logic btn_raw;
    assign btn_raw = ~btn_sync_q[1]; // Pressed while the pin is low

    // Debounce: accept a new button level once stable
    logic [CW-1:0] deb_q;
    logic          btn_q, btn_prev_q;
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            deb_q      <= '0;
            btn_q      <= 1'b0;
            btn_prev_q <= 1'b0;
        end else begin
            btn_prev_q <= btn_q;
            if (btn_raw == btn_q) begin
                deb_q <= '0;
            end else if (deb_q >= CW'(DEBOUNCE_CYC)) begin
                btn_q <= btn_raw;
                deb_q <= '0;
            end else begin
                deb_q <= deb_q + 1'b1;
            end
        end
    end
    logic press, btn_rel;
    assign press   = btn_q & ~btn_prev_q;
    assign btn_rel = ~btn_q & btn_prev_q;

    // Free-running blink square wave
    logic [CW-1:0] blk_q;
    logic          blink_q;
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            blk_q   <= '0;
            blink_q <= 1'b1;
        end else if (blk_q >= CW'(BLINK_CYC - 1)) begin
            blk_q   <= '0;
            blink_q <= ~blink_q;
        end else begin
            blk_q <= blk_q + 1'b1;
        end
    end

    // Main state machine with a shared timer
    rihmi_state_type state_q;
    logic [CW-1:0]   tmr_q;
    logic [1:0]      sel_q;      // 0 test, 1 aim, 2 setup, 3 learn
    logic            sel_shown_q;
    logic            tmo_fail;
    logic            save_done;
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            state_q     <= ST_START;
            tmr_q       <= '0;
            sel_q       <= 2'h0;
            sel_shown_q <= 1'b0;
        end else begin
            tmr_q <= tmr_q + 1'b1;
            case (state_q)
                ST_START: begin
                    if (tmr_q >= CW'(STARTUP_CYC - 1)) begin
                        state_q <= ST_NORMAL;
                    end
                end
                ST_NORMAL: begin
                    tmr_q <= '0;
                    if (press) begin
                        state_q     <= ST_SELECT;
                        sel_q       <= 2'h0;
                        sel_shown_q <= 1'b0;
                    end
                end
                ST_SELECT: begin
                    if (btn_rel) begin
                        tmr_q <= '0;
                        if (!sel_shown_q) begin
                            state_q <= ST_NORMAL;
                        end else begin
                            case (sel_q)
                                2'h0: state_q <= ST_TEST;
                                2'h1: state_q <= ST_AIM;
                                2'h2: state_q <= ST_SETUP;
                                default: state_q <= ST_LEARN;
                            endcase
                        end
                    end else if (tmr_q >= CW'(DWELL_CYC - 1)) begin
                        tmr_q <= '0;
                        if (sel_shown_q) begin
                            sel_q <= sel_q + 1'b1;
                        end
                        sel_shown_q <= 1'b1;
                    end
                end
                ST_TEST: begin
                    if (press || tmr_q >= CW'(TEST_TMO_CYC - 1)) begin
                        state_q <= ST_NORMAL;
                    end
                end
                ST_AIM, ST_LEARN: begin
                    if (press) begin
                        state_q <= ST_EXIT;
                        tmr_q   <= '0;
                    end else if (state_q == ST_LEARN && (save_done || tmo_fail)) begin
                        state_q <= ST_NORMAL;
                    end
                end
                ST_SETUP: begin
                    if (save_done || tmo_fail) begin
                        state_q <= ST_NORMAL;
                    end
                end
                ST_EXIT: begin
                    if (tmr_q >= CW'(EXIT_CYC - 1)) begin
                        state_q <= ST_NORMAL;
                    end
                end
                default: state_q <= ST_START;
            endcase
        end
    end
    assign save_done = EVENTS_I.save_ok;
    assign tmo_fail  = !EVENTS_I.save_ok &&
        ((state_q == ST_SETUP && tmr_q >= CW'(SETUP_TMO_CYC - 1)) ||
         (state_q == ST_LEARN && tmr_q >= CW'(LEARN_TMO_CYC - 1)));

    // Latched decode result for normal indication
    logic last_good_q, last_fail_q;
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            last_good_q <= 1'b0;
            last_fail_q <= 1'b0;
        end else if (EVENTS_I.read_done) begin
            last_good_q <= EVENTS_I.good_read;
            last_fail_q <= EVENTS_I.no_read;
        end
    end

    // Beeper: a count of tones of one pitch and length
    logic [1:0]    beeps_q;
    logic          beep_on_q, beep_hi_q;
    logic [CW-1:0] bt_q;
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            beeps_q   <= 2'h0;
            beep_on_q <= 1'b0;
            beep_hi_q <= 1'b0;
            bt_q      <= '0;
        end else if ((state_q == ST_SETUP || state_q == ST_LEARN) && save_done) begin
            beeps_q   <= 2'h3;
            beep_hi_q <= 1'b1;
            beep_on_q <= 1'b0;
            bt_q      <= '0;
        end else if (tmo_fail) begin
            beeps_q   <= 2'h1;
            beep_hi_q <= 1'b0;
            beep_on_q <= 1'b0;
            bt_q      <= '0;
        end else if (beeps_q != 2'h0) begin
            bt_q <= bt_q + 1'b1;
            if (!beep_on_q && bt_q >= CW'(BEEP_S_CYC - 1)) begin
                beep_on_q <= 1'b1;
                bt_q      <= '0;
            end else if (beep_on_q &&
                         bt_q >= (beep_hi_q ? CW'(BEEP_S_CYC - 1) : CW'(BEEP_L_CYC - 1))) begin
                beep_on_q <= 1'b0;
                bt_q      <= '0;
                beeps_q   <= beeps_q - 1'b1;
            end
        end
    end

    // Lamp pattern and test-mode rate bar
    logic [4:0] lamps_d;
    logic [4:0] bar;
    always_comb begin
        bar = 5'h00;
        for (int i = 0; i < 5; i++) begin
            if (3'(i) < RATE_I) begin
                bar[i] = 1'b1;
            end
        end
        lamps_d = 5'h00;
        case (state_q)
            ST_START: lamps_d = {5{blink_q}};
            ST_NORMAL: begin
                if (EVENTS_I.error) begin
                    lamps_d[`RIHMI_LAMP_STATUS] = blink_q;
                    lamps_d[`RIHMI_LAMP_READY]  = blink_q;
                end else begin
                    lamps_d[`RIHMI_LAMP_STATUS] = last_fail_q;
                    lamps_d[`RIHMI_LAMP_READY]  = EVENTS_I.ready;
                end
                lamps_d[`RIHMI_LAMP_SERIAL]  = EVENTS_I.serial_active | net_s2_q[1];
                lamps_d[`RIHMI_LAMP_TRIGGER] = EVENTS_I.phase_active;
                lamps_d[`RIHMI_LAMP_GOOD]    = last_good_q;
            end
            ST_SELECT: begin
                lamps_d[`RIHMI_LAMP_STATUS] = 1'b1;
                if (sel_shown_q) begin
                    lamps_d[3'(sel_q) + 3'h1] = 1'b1;
                end
            end
            ST_TEST: begin
                if (last_fail_q) begin
                    lamps_d[`RIHMI_LAMP_STATUS] = blink_q;
                end else begin
                    lamps_d = bar;
                end
            end
            ST_AIM:   lamps_d[2] = blink_q;
            ST_SETUP: lamps_d[3] = blink_q;
            ST_LEARN: lamps_d[4] = blink_q;
            ST_EXIT:  lamps_d = 5'h00;
            default:  lamps_d = 5'h00;
        endcase
    end

    // Registered outputs
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            SUPPLY_LAMP_O <= 1'b0;
            NET_LAMP_O    <= 1'b0;
            LAMPS_O       <= 5'h00;
            BEEP_HIGH_O   <= 1'b0;
            BEEP_LOW_O    <= 1'b0;
            GREEN_SPOT_O  <= 1'b0;
            CMD_O         <= '0;
        end else begin
            SUPPLY_LAMP_O     <= 1'b1;
            NET_LAMP_O        <= net_s1_q[1];
            LAMPS_O           <= lamps_d;
            BEEP_HIGH_O       <= beep_on_q & beep_hi_q;
            BEEP_LOW_O        <= beep_on_q & ~beep_hi_q;
            GREEN_SPOT_O      <= (state_q == ST_LEARN) && save_done ? 1'b1 :
                                 (press ? 1'b0 : GREEN_SPOT_O);
            CMD_O.aim_on      <= (state_q == ST_AIM) ||
                                 (state_q == ST_EXIT && CMD_O.aim_on);
            CMD_O.start_setup <= (state_q == ST_SETUP);
            CMD_O.start_learn <= (state_q == ST_LEARN);
            CMD_O.cancel      <= (state_q == ST_EXIT) && (tmr_q >= CW'(EXIT_CYC - 1));
        end
    end
endmodule
`default_nettype wire

// [verif/rihmi_monitor.sv]
// Port assertions for the front-panel controller
`timescale 1ns/10ps
`default_nettype none
module rihmi_monitor
    import rihmi_pkg::*;
#(
    parameter int unsigned STARTUP_CYC = 32,
    parameter int unsigned BEEP_S_CYC  = 4,
    parameter int unsigned BEEP_L_CYC  = 8
) (
    input wire logic          CLK_I,
    input wire logic          RST_I,
    input wire logic          NET_LINK_I,
    input wire logic          SUPPLY_LAMP_O,
    input wire logic          NET_LAMP_O,
    input wire logic [4:0]    LAMPS_O,
    input wire logic          BEEP_HIGH_O,
    input wire logic          BEEP_LOW_O,
    input wire rihmi_cmd_type CMD_O
);
    logic [15:0] st_q;
    logic [15:0] hi_q;
    logic [15:0] lo_q;
    default clocking @(posedge CLK_I); endclocking
    default disable iff (RST_I);
    // Cycles since reset and lengths of the running tones
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            st_q <= 16'h0000;
            hi_q <= 16'h0000;
            lo_q <= 16'h0000;
        end else begin
            st_q <= (st_q < 16'(STARTUP_CYC)) ? st_q + 16'h0001 : st_q;
            hi_q <= BEEP_HIGH_O ? hi_q + 16'h0001 : 16'h0000;
            lo_q <= BEEP_LOW_O ? lo_q + 16'h0001 : 16'h0000;
        end
    end
    a_reset_clear: assert property ($fell(RST_I) |-> !SUPPLY_LAMP_O && LAMPS_O == 5'h00)
        else $error("outputs not clear after reset");
    a_supply_on: assert property (!$past(RST_I) |-> SUPPLY_LAMP_O)
        else $error("supply lamp off while powered");
    a_net_follow: assert property ($stable(NET_LINK_I) [*6] |-> NET_LAMP_O == NET_LINK_I)
        else $error("network lamp does not follow link");
    a_startup_blink: assert property (st_q + 16'h0001 < 16'(STARTUP_CYC) |->
        LAMPS_O inside {5'h00, 5'h1F}) else $error("startup lamps not together");
    a_high_tone: assert property ($fell(BEEP_HIGH_O) |-> hi_q == 16'(BEEP_S_CYC))
        else $error("high tone length wrong");
    a_low_tone: assert property ($fell(BEEP_LOW_O) |-> lo_q == 16'(BEEP_L_CYC))
        else $error("low tone length wrong");
    a_cancel_pulse: assert property (CMD_O.cancel |=> !CMD_O.cancel)
        else $error("cancel longer than one cycle");
    a_one_function: assert property (
        $onehot0({CMD_O.aim_on, CMD_O.start_setup, CMD_O.start_learn}))
        else $error("two functions active");
    a_tone_excl: assert property (!(BEEP_HIGH_O && BEEP_LOW_O))
        else $error("both tones on");
    c_high_tone: cover property ($rose(BEEP_HIGH_O));
    c_low_tone: cover property ($rose(BEEP_LOW_O));
    c_cancel: cover property (CMD_O.cancel);
endmodule
bind rihmi_top rihmi_monitor #(
    .STARTUP_CYC(STARTUP_CYC), .BEEP_S_CYC(BEEP_S_CYC), .BEEP_L_CYC(BEEP_L_CYC)
) u_mon (.CLK_I(CLK_I), .RST_I(RST_I), .NET_LINK_I(NET_LINK_I), .SUPPLY_LAMP_O(SUPPLY_LAMP_O),
    .NET_LAMP_O(NET_LAMP_O), .LAMPS_O(LAMPS_O), .BEEP_HIGH_O(BEEP_HIGH_O),
    .BEEP_LOW_O(BEEP_LOW_O), .CMD_O(CMD_O));
`default_nettype wire

// [verif/rihmi_operator.sv]
// Operator model that holds the push button for a given time
`timescale 1ns/10ps
`default_nettype none
module rihmi_operator (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        go_i,
    input  wire logic [15:0] hold_i,
    output logic             button_n_o
);
    logic [15:0] left_q;
    // Keeps the button down until the requested hold runs out
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            left_q <= 16'h0000;
        end else if (go_i) begin
            left_q <= hold_i;
        end else if (left_q != 16'h0000) begin
            left_q <= left_q - 16'h0001;
        end
    end
    // Released button reads high through its pull-up
    assign button_n_o = (left_q == 16'h0000);
endmodule
`default_nettype wire

// [verif/test_reader_indicator_button_hmi.sv]
// Self-checking testbench of the front-panel controller
`timescale 1ns/10ps
`default_nettype none
module test_reader_indicator_button_hmi;
    import rihmi_pkg::*;
    localparam int DW = 16;
    // Shortened timing counts of the design under test
    localparam int unsigned T_START = 32;
    localparam int unsigned T_TEST  = 64;
    localparam int unsigned T_SETUP = 48;
    localparam int unsigned T_LEARN = 80;
    localparam int unsigned T_BLINK = 4;
    localparam int unsigned T_EXIT  = 8;
    localparam int unsigned T_BEEPS = 4;
    localparam int unsigned T_BEEPL = 8;
    localparam int unsigned T_DEB   = 2;
    localparam rihmi_events_type EV_NO = 8'hA0;
    localparam rihmi_events_type EV_GOOD = 8'hC0;
    localparam rihmi_events_type EV_SAVE = 8'h01;
    logic clk, rst, go, network_link_indicator, fbus, button_n, supply, net_lamp, beep_hi, beep_lo, spot;
    logic hi_p, lo_p, cancel_seen;
    logic [15:0] hold;
    logic [4:0] lamps;
    logic [2:0] rate;
    rihmi_events_type ev;
    rihmi_cmd_type cmd;
    int num_errors, check_count, hi_n, lo_n;
    // Clock of 25 ns
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    rihmi_top #(.STARTUP_CYC(T_START), .TEST_TMO_CYC(T_TEST), .SETUP_TMO_CYC(T_SETUP),
        .LEARN_TMO_CYC(T_LEARN), .DWELL_CYC(DW), .BLINK_CYC(T_BLINK), .EXIT_CYC(T_EXIT),
        .BEEP_S_CYC(T_BEEPS), .BEEP_L_CYC(T_BEEPL), .DEBOUNCE_CYC(T_DEB)) u_dut (
        .CLK_I(clk), .RST_I(rst), .BUTTON_N_I(button_n),
        .NET_LINK_I(network_link_indicator), .FIELDBUS_I(fbus), .EVENTS_I(ev), .RATE_I(rate),
        .SUPPLY_LAMP_O(supply), .NET_LAMP_O(net_lamp), .LAMPS_O(lamps), .BEEP_HIGH_O(beep_hi),
        .BEEP_LOW_O(beep_lo), .GREEN_SPOT_O(spot), .CMD_O(cmd));
    rihmi_operator u_op (.clk_i(clk), .rst_i(rst), .go_i(go), .hold_i(hold),
        .button_n_o(button_n));
    // Counts tone starts and catches the one-cycle cancel
    always @(posedge clk) begin
        hi_p <= beep_hi;
        lo_p <= beep_lo;
        if (beep_hi && !hi_p) hi_n++;
        if (beep_lo && !lo_p) lo_n++;
        if (cmd.cancel) cancel_seen = 1'b1;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic clr();
        hi_n = 0;
        lo_n = 0;
        cancel_seen = 1'b0;
    endtask
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic press(input int n);
        @(posedge clk);
        go <= 1'b1;
        hold <= 16'(n);
        @(posedge clk);
        go <= 1'b0;
        #1;
    endtask
    task automatic pulse(input rihmi_events_type m);
        @(posedge clk);
        ev <= ev | m;
        @(posedge clk);
        ev <= ev & ~m;
        tick(3);
    endtask
    // Holds the button through k dwells, then releases
    task automatic sel(input int k);
        press(13 + k * DW);
        tick(4 + DW / 2);
        check("select status", 8'(lamps[0]), 8'h01);
        for (int i = 1; i <= k; i++) begin
            tick(DW);
            check("select lamp", 8'(lamps[i]), 8'h01);
        end
        tick(12);
    endtask
    task automatic toggles(input string what, input int idx);
        logic [1:0] seen;
        seen = 2'b00;
        repeat (20) begin
            tick(1);
            seen[lamps[idx]] = 1'b1;
        end
        check(what, 8'(seen), 8'h03);
    endtask
    task automatic t_start();
        toggles("startup blink", 0);
        check("supply", 8'(supply), 8'h01);
        tick(16);
        check("ready", 8'(lamps), 8'h10);
        check("net on", 8'(net_lamp), 8'h01);
    endtask
    task automatic t_normal();
        pulse(EV_NO);
        check("no read", 8'(lamps[0]), 8'h01);
        @(posedge clk);
        ev.serial_active <= 1'b1;
        ev.phase_active <= 1'b1;
        tick(3);
        check("serial", 8'(lamps[1]), 8'h01);
        check("trigger", 8'(lamps[2]), 8'h01);
        pulse(EV_GOOD);
        check("good", 8'(lamps[3]), 8'h01);
        @(posedge clk);
        ev <= 8'h04;
        fbus <= 1'b1;
        network_link_indicator <= 1'b0;
        tick(8);
        check("fieldbus serial", 8'(lamps[1]), 8'h01);
        check("net off", 8'(net_lamp), 8'h00);
        @(posedge clk);
        fbus <= 1'b0;
        network_link_indicator <= 1'b1;
        ev.error <= 1'b1;
        tick(3);
        toggles("error blink", 4);
        toggles("error status", 0);
        repeat (8) begin
            tick(1);
            check("error pair", 8'(lamps[0]), 8'(lamps[4]));
        end
        @(posedge clk);
        ev.error <= 1'b0;
    endtask
    task automatic t_test();
        sel(1);
        @(posedge clk);
        rate <= 3'h3;
        pulse(EV_GOOD);
        check("bar three", 8'(lamps), 8'h07);
        pulse(EV_NO);
        toggles("no read blink", 0);
        check("bar off", 8'(lamps[4:1]), 8'h00);
        press(10);
        tick(14);
        check("test left", 8'(lamps), 8'h11);
        sel(1);
        @(posedge clk);
        rate <= 3'h5;
        pulse(EV_GOOD);
        check("bar five", 8'(lamps), 8'h1F);
        tick(74);
        check("test timeout", 8'(lamps), 8'h18);
    endtask
    task automatic t_aim();
        sel(2);
        check("pointers on", 8'(cmd.aim_on), 8'h01);
        toggles("aim blink", 2);
        press(10);
        tick(6);
        check("pointers linger", 8'(cmd.aim_on), 8'h01);
        for (int i = 0; i < 30 && cmd.aim_on; i++) tick(1);
        check("pointers off", 8'(cmd.aim_on), 8'h00);
    endtask
    task automatic t_setup();
        sel(3);
        check("setup on", 8'(cmd.start_setup), 8'h01);
        toggles("setup blink", 3);
        clr();
        pulse(EV_SAVE);
        tick(40);
        check("setup beeps", 8'(hi_n), 8'h03);
        check("setup done", 8'({lo_n[3:0], 3'h0, cmd.start_setup}), 8'h00);
        sel(3);
        clr();
        tick(68);
        check("setup fail", 8'({hi_n[3:0], lo_n[3:0]}), 8'h01);
    endtask
    task automatic t_learn();
        sel(4);
        check("learn on", 8'(cmd.start_learn), 8'h01);
        toggles("learn blink", 4);
        clr();
        pulse(EV_SAVE);
        tick(40);
        check("learn beeps", 8'({spot, 3'h0, hi_n[3:0]}), 8'h83);
        sel(4);
        clr();
        press(10);
        tick(20);
        check("learn cancel", 8'({spot, 5'h00, cancel_seen, cmd.start_learn}), 8'h02);
        sel(4);
        clr();
        tick(100);
        check("learn fail", 8'({hi_n[3:0], lo_n[3:0]}), 8'h01);
    endtask
    // Restart in mid-run, then a press released before the first dwell
    task automatic t_restart();
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        toggles("restart blink", 4);
        tick(16);
        check("restart ready", 8'(lamps), 8'h10);
        press(5);
        tick(16);
        check("short press", 8'(lamps), 8'h10);
    endtask
    task automatic print_verdict();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // Cuts a hang short
    initial begin
        #125000;
        num_errors++;
        print_verdict();
    end
    // Main sequence
    initial begin
        rst = 1'b1;
        go = 1'b0;
        hold = 16'h0000;
        network_link_indicator = 1'b1;
        fbus = 1'b0;
        ev = 8'h04;
        rate = 3'h0;
        num_errors = 0;
        check_count = 0;
        clr();
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        t_start();
        t_normal();
        t_test();
        t_aim();
        t_setup();
        t_learn();
        t_restart();
        print_verdict();
    end
endmodule
`default_nettype wire
